// *** design/pps_sequencer.sv ***
/*
 * Power sequencer: reset release, auto-initialisation, status line,
 * normal and fast mirror parking, pin gating during reset.
 * Assumes i_mclk at 40 MHz and a synchronous internal reset i_rst.
 */
// Contract
// - Power request high runs, low shuts down
// - Reset release starts automatic initialization
// - Initialization done drives status low
// - Normal park completes within 20 ms
// - Status line released during reset
// - Fast-park low starts fast park immediately
// - Flash and general pins tri-stated in reset
// - Light selects and mirror enable low
// - Status driven high until initialization done
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer
   import pps_pkg::*;
#(
   parameter int P_INIT_CYC   = pps_pkg::INIT_CYC,
   parameter int P_NPARK_CYC  = pps_pkg::NORMAL_PARK_CYC,
   parameter int P_FPARK_CYC  = pps_pkg::FAST_PARK_CYC
) (
   input  wire logic                          i_mclk,
   input  wire logic                          i_rst,
   input  wire logic                          i_system_rst_n,
   input  wire logic                          i_power_request,
   input  wire logic                          i_fast_park_req_n,
   input  wire logic [1:0]                    i_light_select_req,
   input  wire logic                          i_spi_clk,
   input  wire logic                          i_spi_dout,
   input  wire logic [pps_pkg::SPI_CS_W-1:0]  i_spi_cs_n,
   input  wire logic [pps_pkg::GPIO_W-1:0]    i_gpio_out,
   input  wire logic [pps_pkg::GPIO_W-1:0]    i_gpio_oe,
   output logic                               o_init_status,
   output logic                               o_init_status_oe,
   output logic                               o_light_select_0,
   output logic                               o_light_select_1,
   output logic                               o_mirror_enable_rst_n,
   output logic                               o_spi_clk,
   output logic                               o_spi_dout,
   output logic [pps_pkg::SPI_CS_W-1:0]       o_spi_cs_n,
   output logic                               o_pin_oe,
   output logic [pps_pkg::GPIO_W-1:0]         o_gpio_out,
   output logic [pps_pkg::GPIO_W-1:0]         o_gpio_oe,
   output logic                               o_bus_enable,
   output logic                               o_parked,
   output logic [2:0]                         o_state
);
   import pps_pkg::*;

   if (P_INIT_CYC < 1 || P_NPARK_CYC < 1 || P_FPARK_CYC < 1 ||
       P_NPARK_CYC >= (1 << CNT_W) || P_INIT_CYC >= (1 << CNT_W) ||
       P_FPARK_CYC >= (1 << CNT_W)) begin : g_bad_cnt
      $error("pps_sequencer: cycle counts out of range");
   end

   // ==========================================================
   // Input synchronisation
   // ==========================================================
   pps_sync_if sync_bus ();

   pps_sync u_sync (
      .i_mclk            (i_mclk),
      .i_rst             (i_rst),
      .i_power_request   (i_power_request),
      .i_fast_park_req_n (i_fast_park_req_n),
      .o_sync            (sync_bus)
   );

   // ==========================================================
   // Reset pin edge detect
   // ==========================================================
   logic       rstn_ff;
   logic       nxt_rstn;
   logic       in_reset;
   logic       rst_release;

   always_comb begin
      nxt_rstn    = i_system_rst_n;
      in_reset    = ~i_system_rst_n;
      rst_release = i_system_rst_n & ~rstn_ff;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) rstn_ff <= 1'b0;
      else       rstn_ff <= nxt_rstn;
   end

   // ==========================================================
   // Sequencer state and timer
   // ==========================================================
   localparam logic [CNT_W-1:0] INIT_LAST  = CNT_W'(P_INIT_CYC - 1);
   localparam logic [CNT_W-1:0] NPARK_LAST = CNT_W'(P_NPARK_CYC - 1);
   localparam logic [CNT_W-1:0] FPARK_LAST = CNT_W'(P_FPARK_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO   = '0;
   localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

   pps_state_t       state_ff;
   pps_state_t       nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic             req;
   logic             fpark;

   always_comb begin
      req       = sync_bus.power_request;
      fpark     = ~sync_bus.fast_park_req_n;
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + CNT_ONE;
      if (in_reset) begin
         nxt_state = PPS_OFF;
         nxt_cnt   = CNT_ZERO;
      end else if (fpark && state_ff != PPS_FPARK &&
                   state_ff != PPS_PARKED) begin
         nxt_state = PPS_FPARK;
         nxt_cnt   = CNT_ZERO;
      end else begin
         case (state_ff)
            PPS_OFF: begin
               nxt_cnt = CNT_ZERO;
               if (rst_release) nxt_state = PPS_INIT;
            end
            PPS_INIT: begin
               // Request checked at the last init count: high goes to PPS_ON, low to PPS_NPARK
               if (cnt_ff == INIT_LAST) begin
                  nxt_state = req ? PPS_ON : PPS_NPARK;
                  nxt_cnt   = CNT_ZERO;
               end
            end
            PPS_ON: begin
               nxt_cnt = CNT_ZERO;
               if (!req) nxt_state = PPS_NPARK;
            end
            PPS_NPARK: begin
               if (cnt_ff == NPARK_LAST) begin
                  nxt_state = PPS_PARKED;
                  nxt_cnt   = CNT_ZERO;
               end
            end
            PPS_FPARK: begin
               if (cnt_ff == FPARK_LAST) begin
                  nxt_state = PPS_PARKED;
                  nxt_cnt   = CNT_ZERO;
               end
            end
            PPS_PARKED: begin
               nxt_cnt = CNT_ZERO;
               // Restart from the parked state while the request is high and fast park is not asserted
               if (req && !fpark) nxt_state = PPS_ON;
            end
            default: begin
               nxt_state = PPS_OFF;
               nxt_cnt   = CNT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_ff <= PPS_OFF;
         cnt_ff   <= CNT_ZERO;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // ==========================================================
   // Registered pin outputs
   // ==========================================================
   logic                 stat_ff,  nxt_stat;
   logic                 stoe_ff,  nxt_stoe;
   logic [1:0]           led_ff,   nxt_led;
   logic                 mir_ff,   nxt_mir;
   logic                 pinoe_ff, nxt_pinoe;
   logic                 sclk_ff,  nxt_sclk;
   logic                 sdo_ff,   nxt_sdo;
   logic [SPI_CS_W-1:0]  scs_ff,   nxt_scs;
   logic [GPIO_W-1:0]    go_ff,    nxt_go;
   logic [GPIO_W-1:0]    goe_ff,   nxt_goe;
   logic                 busen_ff, nxt_busen;
   logic                 running;

   always_comb begin
      running   = (nxt_state == PPS_ON);
      nxt_stoe  = ~in_reset;
      nxt_stat  = (nxt_state == PPS_INIT);
      nxt_pinoe = ~in_reset;
      nxt_sclk  = in_reset ? 1'b0 : i_spi_clk;
      nxt_sdo   = in_reset ? 1'b0 : i_spi_dout;
      nxt_scs   = in_reset ? '1 : i_spi_cs_n;
      nxt_go    = in_reset ? '0 : i_gpio_out;
      nxt_goe   = in_reset ? '0 : i_gpio_oe;
      nxt_led   = running ? i_light_select_req : 2'h0;
      nxt_mir   = running;
      nxt_busen = ~in_reset && nxt_state != PPS_OFF &&
                  nxt_state != PPS_INIT;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         stat_ff  <= 1'b0;
         stoe_ff  <= 1'b0;
         led_ff   <= 2'h0;
         mir_ff   <= 1'b0;
         pinoe_ff <= 1'b0;
         sclk_ff  <= 1'b0;
         sdo_ff   <= 1'b0;
         scs_ff   <= '1;
         go_ff    <= '0;
         goe_ff   <= '0;
         busen_ff <= 1'b0;
      end else begin
         stat_ff  <= nxt_stat;
         stoe_ff  <= nxt_stoe;
         led_ff   <= nxt_led;
         mir_ff   <= nxt_mir;
         pinoe_ff <= nxt_pinoe;
         sclk_ff  <= nxt_sclk;
         sdo_ff   <= nxt_sdo;
         scs_ff   <= nxt_scs;
         go_ff    <= nxt_go;
         goe_ff   <= nxt_goe;
         busen_ff <= nxt_busen;
      end
   end

   assign o_init_status         = stat_ff;
   assign o_init_status_oe      = stoe_ff;
   assign o_light_select_0      = led_ff[0];
   assign o_light_select_1      = led_ff[1];
   assign o_mirror_enable_rst_n = mir_ff;
   assign o_spi_clk             = sclk_ff;
   assign o_spi_dout            = sdo_ff;
   assign o_spi_cs_n            = scs_ff;
   assign o_pin_oe              = pinoe_ff;
   assign o_gpio_out            = go_ff;
   assign o_gpio_oe             = goe_ff;
   assign o_bus_enable          = busen_ff;
   assign o_parked              = (state_ff == PPS_PARKED);
   assign o_state               = state_ff;
endmodule : pps_sequencer
`default_nettype wire

// *** design/pps_pkg.sv ***
/*
 * Constants, states and timing figures of the power sequencer.
 * Assumes a single 40 MHz clock; the park cycle counts derive from it.
 */
package pps_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_HZ          = 40_000_000;
   localparam int NORMAL_PARK_MS  = 20;
   localparam int FAST_PARK_US    = 32;
   // Longest times round down
   localparam int NORMAL_PARK_CYC = (CLK_HZ / 1000) * NORMAL_PARK_MS;
   localparam int FAST_PARK_CYC   = (CLK_HZ / 1_000_000) * FAST_PARK_US;
   localparam int INIT_CYC        = 1000;
   localparam int CNT_W           = 24;
   localparam int GPIO_W          = 20;
   localparam int SPI_CS_W        = 2;

   // ==========================================================
   // Sequencer states
   // ==========================================================
   typedef enum logic [2:0] {
      PPS_OFF    = 3'b000,
      PPS_INIT   = 3'b001,
      PPS_ON     = 3'b010,
      PPS_NPARK  = 3'b011,
      PPS_FPARK  = 3'b100,
      PPS_PARKED = 3'b101
   } pps_state_t;
endpackage : pps_pkg

// *** design/pps_sync_if.sv ***
/*
 * Carries synchronised control levels from the input stage to the sequencer.
 * Assumes both ends share i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface pps_sync_if;
   logic power_request;
   logic fast_park_req_n;
   modport src (output power_request, output fast_park_req_n);
   modport dst (input power_request, input fast_park_req_n);
endinterface : pps_sync_if
`default_nettype wire

// *** design/pps_sync.sv ***
/*
 * Two-stage synchroniser for the power request and fast-park inputs.
 * Assumes i_mclk; first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module pps_sync (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_power_request,
   input  wire logic i_fast_park_req_n,
   pps_sync_if.src   o_sync
);
   logic [1:0] pr_ff;
   logic [1:0] nxt_pr;
   logic [1:0] fp_ff;
   logic [1:0] nxt_fp;

   always_comb begin
      nxt_pr = {pr_ff[0], i_power_request};
      nxt_fp = {fp_ff[0], i_fast_park_req_n};
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pr_ff <= 2'h0;
         fp_ff <= 2'h3;
      end else begin
         pr_ff <= nxt_pr;
         fp_ff <= nxt_fp;
      end
   end

   assign o_sync.power_request   = pr_ff[1];
   assign o_sync.fast_park_req_n = fp_ff[1];
endmodule : pps_sync
`default_nettype wire

// *** bench/pps_asserts.sv ***
/*
 * Port assertions of the power sequencer.
 * Assumes a bind into pps_sequencer and one i_mclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pps_asserts #(
   parameter int P_INIT_CYC  = 4,
   parameter int P_NPARK_CYC = 16,
   parameter int P_FPARK_CYC = 8
) (
   input wire logic       i_mclk,
   input wire logic       i_rst,
   input wire logic       i_system_rst_n,
   input wire logic       i_power_request,
   input wire logic       i_fast_park_req_n,
   input wire logic       o_init_status,
   input wire logic       o_init_status_oe,
   input wire logic       o_light_select_0,
   input wire logic       o_light_select_1,
   input wire logic       o_mirror_enable_rst_n,
   input wire logic       o_pin_oe,
   input wire logic       o_bus_enable,
   input wire logic [2:0] o_state
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // Park entry steps
   // ==========================================================
   sequence s_drop;
      o_state == 3'h2 && $fell(i_power_request) && i_fast_park_req_n;
   endsequence
   sequence s_npark_entry;
      ##1 o_state == 3'h2 ##[1:2] o_state == 3'h3;
   endsequence
   // ==========================================================
   // Properties
   // ==========================================================
   pin_release_a: assert property (!i_system_rst_n |=>
      !o_init_status_oe && !o_pin_oe && o_state == 3'h0)
      else $error("outputs still driven under reset pin");
   light_low_a: assert property (!i_system_rst_n |=>
      !o_light_select_0 && !o_light_select_1 && !o_mirror_enable_rst_n)
      else $error("light or mirror output high under reset pin");
   init_start_a: assert property ($rose(i_system_rst_n) |=>
      o_state == 3'h1 && o_init_status && o_init_status_oe)
      else $error("no init with status high after release");
   init_length_a: assert property ($rose(o_state == 3'h1)
      ##0 i_power_request |-> ##P_INIT_CYC (o_state == 3'h2 && !o_init_status))
      else $error("init did not end with status low in time");
   bus_gate_a: assert property ($rose(o_bus_enable) |->
      !o_init_status && o_init_status_oe)
      else $error("bus enabled before status low");
   npark_start_a: assert property (s_drop |-> s_npark_entry)
      else $error("normal park not entered two to three cycles on");
   npark_length_a: assert property ($rose(o_state == 3'h3) |->
      ##P_NPARK_CYC o_state == 3'h5)
      else $error("normal park length wrong");
   fpark_start_a: assert property ($fell(i_fast_park_req_n) &&
      o_state inside {3'h2, 3'h3} && i_system_rst_n |->
      ##1 o_state != 3'h4 ##[1:2] o_state == 3'h4)
      else $error("fast park not entered two to three cycles on");
   fpark_length_a: assert property ($rose(o_state == 3'h4) |->
      ##P_FPARK_CYC o_state == 3'h5)
      else $error("fast park length wrong");
endmodule : pps_asserts
bind pps_sequencer pps_asserts #(.P_INIT_CYC(P_INIT_CYC),
   .P_NPARK_CYC(P_NPARK_CYC), .P_FPARK_CYC(P_FPARK_CYC)) u_chk (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_system_rst_n(i_system_rst_n),
   .i_power_request(i_power_request), .i_fast_park_req_n(i_fast_park_req_n),
   .o_init_status(o_init_status), .o_init_status_oe(o_init_status_oe),
   .o_light_select_0(o_light_select_0), .o_light_select_1(o_light_select_1),
   .o_mirror_enable_rst_n(o_mirror_enable_rst_n), .o_pin_oe(o_pin_oe),
   .o_bus_enable(o_bus_enable), .o_state(o_state));
`default_nettype wire

// *** bench/pps_partner.sv ***
/*
 * Supervisor and host model: reset pin, power request, fast park.
 * Assumes the bench calls its tasks and sees the pulled-up status line.
 */
`timescale 1ns/1ps
`default_nettype none
module pps_partner #(
   parameter int P_HOLD_CYC = 8
) (
   input  wire logic i_mclk,
   input  wire logic i_init_line,
   output logic      o_system_rst_n,
   output logic      o_power_request,
   output logic      o_fast_park_req_n
);
   // ==========================================================
   // Supervisor and host actions
   // ==========================================================
   initial begin
      o_system_rst_n    = 1'h0;
      o_power_request   = 1'h0;
      o_fast_park_req_n = 1'h1;
   end
   task automatic power_up();
      repeat (P_HOLD_CYC) @(posedge i_mclk);
      #2 o_fast_park_req_n = 1'h1;
      o_power_request = 1'h1;
      @(posedge i_mclk);
      #2 o_system_rst_n = 1'h1;
   endtask : power_up
   // Bus idle already; clock keeps running
   task automatic drop_request(output logic late);
      for (int i = 0; i < 40 && i_init_line !== 1'h0; i++)
         @(posedge i_mclk);
      late = (i_init_line !== 1'h0);
      @(posedge i_mclk);
      #2 o_power_request = 1'h0;
   endtask : drop_request
   // Fresh request from the parked state
   task automatic raise_request();
      @(posedge i_mclk);
      #2 o_power_request = 1'h1;
   endtask : raise_request
   task automatic warn_park();
      @(posedge i_mclk);
      #2 o_fast_park_req_n = 1'h0;
   endtask : warn_park
   task automatic hold_reset();
      @(posedge i_mclk);
      #2 o_system_rst_n = 1'h0;
      o_power_request = 1'h0;
      o_fast_park_req_n = 1'h1;
   endtask : hold_reset
endmodule : pps_partner
`default_nettype wire

// *** bench/testbench.sv ***
/*
 * Testbench of the power sequencer with a supervisor model.
 * Assumes small park and init counts set by parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pps_pkg::*;
   localparam int P_INIT  = 4;
   localparam int P_NPARK = 16;
   localparam int P_FPARK = 8;
   logic        i_mclk, i_rst, i_system_rst_n, i_power_request;
   logic        i_fast_park_req_n, o_init_status, o_init_status_oe;
   logic        o_light_select_0, o_light_select_1, o_mirror_enable_rst_n;
   logic        o_pin_oe, o_bus_enable, o_parked, o_spi_clk, o_spi_dout;
   logic [1:0]  i_light_select_req, i_spi_cs_n, o_spi_cs_n;
   logic [19:0] i_gpio_oe, o_gpio_oe, o_gpio_out;
   logic [2:0]  o_state;
   int          error_cnt, compares;
   wire logic   status_line = o_init_status_oe ? o_init_status : 1'h1;
   // ==========================================================
   // Design and partner
   // ==========================================================
   pps_sequencer #(.P_INIT_CYC(P_INIT), .P_NPARK_CYC(P_NPARK),
      .P_FPARK_CYC(P_FPARK)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_system_rst_n(i_system_rst_n), .i_power_request(i_power_request),
      .i_fast_park_req_n(i_fast_park_req_n), .i_spi_clk(1'h1),
      .i_light_select_req(i_light_select_req), .i_spi_dout(1'h1),
      .i_spi_cs_n(i_spi_cs_n), .i_gpio_out(20'ha_5a5a), .i_gpio_oe(i_gpio_oe),
      .o_init_status(o_init_status), .o_init_status_oe(o_init_status_oe),
      .o_light_select_0(o_light_select_0), .o_light_select_1(o_light_select_1),
      .o_mirror_enable_rst_n(o_mirror_enable_rst_n), .o_spi_clk(o_spi_clk),
      .o_spi_dout(o_spi_dout), .o_spi_cs_n(o_spi_cs_n), .o_pin_oe(o_pin_oe),
      .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe),
      .o_bus_enable(o_bus_enable), .o_parked(o_parked), .o_state(o_state));
   pps_partner partner (.i_mclk(i_mclk), .i_init_line(status_line),
      .o_system_rst_n(i_system_rst_n), .o_power_request(i_power_request),
      .o_fast_park_req_n(i_fast_park_req_n));
   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic ran_out();
      error_cnt++;
      $display("FAIL %0t wait ran out", $time);
      give_verdict();
   endtask : ran_out
   task automatic wait_state(input logic [2:0] s, input int lim);
      for (int n = 0; n < lim && o_state !== s; n++) begin
         @(posedge i_mclk);
         #1;
      end
      if (o_state !== s) ran_out();
   endtask : wait_state
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic sc_in_reset();
      @(posedge i_mclk);
      #1;
      check({status_line, o_init_status_oe, o_pin_oe, o_gpio_oe},
         23'h40_0000);
      check({o_light_select_0, o_light_select_1,
         o_mirror_enable_rst_n}, 3'h0);
      check({o_spi_clk, o_spi_dout, o_spi_cs_n, o_gpio_out},
         {1'h0, 1'h0, 2'h3, 20'h0_0000});
   endtask : sc_in_reset
   task automatic sc_start_up();
      partner.power_up();
      repeat (2) @(posedge i_mclk);
      #1;
      check({o_state, status_line,
         o_init_status_oe, o_bus_enable}, 6'h0e);
      wait_state(3'h2, P_INIT + 2);
      check({status_line, o_bus_enable, o_mirror_enable_rst_n}, 3'h3);
      repeat (3) @(posedge i_mclk);
      #1;
      check({o_light_select_1, o_light_select_0, o_pin_oe,
         o_gpio_oe, o_spi_cs_n}, {2'h2, 1'h1, 20'h5_a5a5, 2'h2});
      check({o_spi_clk, o_spi_dout, o_gpio_out},
         {2'h3, 20'ha_5a5a});
   endtask : sc_start_up
   task automatic sc_park_done();
      check({o_parked, o_mirror_enable_rst_n}, 2'h2);
      partner.hold_reset();
      repeat (2) @(posedge i_mclk);
      #1;
      check({o_state, status_line, o_init_status_oe}, 5'h02);
      sc_in_reset();
   endtask : sc_park_done
   task automatic sc_normal_park();
      logic late;
      sc_start_up();
      partner.drop_request(late);
      if (late) ran_out();
      wait_state(3'h3, 5);
      check(o_mirror_enable_rst_n, 1'h0);
      wait_state(3'h5, P_NPARK + 1);
      check({o_parked, o_mirror_enable_rst_n}, 2'h2);
      partner.raise_request();
      wait_state(3'h2, 4);
      check({o_parked, o_mirror_enable_rst_n, o_bus_enable}, 3'h3);
      partner.drop_request(late);
      if (late) ran_out();
      wait_state(3'h5, P_NPARK + 5);
      sc_park_done();
   endtask : sc_normal_park
   task automatic sc_fast_park();
      sc_start_up();
      partner.warn_park();
      wait_state(3'h4, 4);
      check(o_mirror_enable_rst_n, 1'h0);
      wait_state(3'h5, P_FPARK + 1);
      sc_park_done();
   endtask : sc_fast_park
   // ==========================================================
   // Clock and main sequence
   // ==========================================================
   initial begin
      i_mclk = 1'h0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   initial begin
      i_rst = 1'h1;
      i_light_select_req = 2'h2;
      i_spi_cs_n = 2'h2;
      i_gpio_oe = 20'h5_a5a5;
      error_cnt = 0;
      compares = 0;
      repeat (6) @(posedge i_mclk);
      #2 i_rst = 1'h0;
      sc_in_reset();
      sc_normal_park();
      sc_fast_park();
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
